//--- clpo_consts.svh
// constants of the two-tap camera link pixel output block
// ==========================================================
// Notes on behaviour
// - pipeline takes 14-bit converter samples for every pixel of every colour line
// - input selector feeds converter samples or test pattern into the chain
// - order: black level, shading, brightness/contrast, realign, matrix, grey
// - optional auxiliary words appended to each line after all corrections
// - colour: front tap leaves on connector one, rear tap on connector two
// - colour: one pixel per pixel enable per connector, red, green, blue ports
// - grey: connector one only, front pixel port one, rear pixel port two
// - line scan mode without frame valid, area scan mode brackets frames
// - data bits mapped to serializer inputs by base configuration assignment
// - frame emulation: trigger starts a frame, height fixed or external signal
`ifndef CLPO_CONSTS_SVH
`define CLPO_CONSTS_SVH
// ==========================================================
// widths
`define CLPO_ADC_W 14
`define CLPO_BYTE_W 8
`define CLPO_GAIN_W 8
`define CLPO_GAIN_SH 7
`define CLPO_HEIGHT_W 16
`define CLPO_AUX_CNT_W 4
`define CLPO_TX_W 28
`define CLPO_POS_W 5
`define CLPO_POS_LIST_W 40
// ==========================================================
// defaults
`define CLPO_LINE_PIX 16
`define CLPO_LINE_GAP 4
`define CLPO_AUX_WORDS 2
// ==========================================================
// serializer input positions, bit 7 first
`define CLPO_TX_POS_A {5'h05, 5'h1b, 5'h06, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00}
`define CLPO_TX_POS_B {5'h0b, 5'h0a, 5'h0e, 5'h0d, 5'h0c, 5'h09, 5'h08, 5'h07}
`define CLPO_TX_POS_C {5'h11, 5'h10, 5'h16, 5'h15, 5'h14, 5'h13, 5'h12, 5'h0f}
`define CLPO_TX_SPARE 23
`define CLPO_TX_LVAL 24
`define CLPO_TX_FVAL 25
`define CLPO_TX_DVAL 26
`endif

//--- clpo_pkg.sv
// types shared by the pixel output block
`default_nettype none
`include "clpo_consts.svh"
package clpo_pkg;
    typedef logic [`CLPO_ADC_W-1:0] clpo_sample_type;
    typedef logic [`CLPO_BYTE_W-1:0] clpo_byte_type;
    typedef logic [`CLPO_GAIN_W-1:0] clpo_gain_type;
    typedef struct packed {
        clpo_sample_type r;
        clpo_sample_type g;
        clpo_sample_type b;
    } clpo_pix_type;
    typedef struct packed {
        logic vld;
        logic first;
        logic last;
        clpo_pix_type front;
        clpo_pix_type rear;
    } clpo_tap_in_type;
    typedef struct packed {
        clpo_sample_type black;
        clpo_gain_type gain;
        clpo_sample_type bright;
        clpo_gain_type contrast;
    } clpo_corr_type;
    typedef struct packed {
        clpo_byte_type r;
        clpo_byte_type g;
        clpo_byte_type b;
    } clpo_rgb8_type;
    typedef struct packed {
        logic frame_first;
        logic frame_last;
        logic line_first;
        logic line_last;
    } clpo_flags_type;
    typedef struct packed {
        clpo_flags_type flags;
        clpo_rgb8_type con1;
        clpo_rgb8_type con2;
    } clpo_word_type;
    typedef struct packed {
        logic lval;
        logic fval;
        logic pen;
    } clpo_ctrl_type;
    typedef enum logic [2:0] {
        CLPO_FR_IDLE = 3'b001,
        CLPO_FR_ARMED = 3'b010,
        CLPO_FR_ACTIVE = 3'b100
    } clpo_frame_type;
endpackage
`default_nettype wire

//--- clpo_tap_chain.sv
// correction chain of one tap, from sample to 8-bit colour
`include "clpo_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module clpo_tap_chain #(
    parameter int LINE_PIX = `CLPO_LINE_PIX,
    parameter int LINE_GAP = `CLPO_LINE_GAP,
    localparam int CW = $clog2(LINE_PIX),
    localparam int PBW = $clog2(2 * LINE_GAP),
    localparam int PGW = $clog2(LINE_GAP)
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic vld_i,
    input wire logic first_i,
    input wire logic [CW-1:0] col_i,
    input wire clpo_pkg::clpo_pix_type pix_i,
    input wire clpo_pkg::clpo_corr_type corr_i,
    output logic vld_o,
    output clpo_pkg::clpo_rgb8_type rgb_o
);
    if (LINE_PIX < 2 || LINE_GAP < 2) begin : g_chk
        $error("line length and line gap must both be at least two");
    end
    // ==========================================================
    // arithmetic
    function automatic clpo_pkg::clpo_sample_type sub_sat(clpo_pkg::clpo_sample_type a, clpo_pkg::clpo_sample_type b);
        return (a > b) ? a - b : '0;
    endfunction
    function automatic clpo_pkg::clpo_sample_type add_sat(clpo_pkg::clpo_sample_type a, clpo_pkg::clpo_sample_type b);
        logic [`CLPO_ADC_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[`CLPO_ADC_W] ? '1 : s[`CLPO_ADC_W-1:0];
    endfunction
    // gain with one at 2^GAIN_SH, clipped at full scale
    function automatic clpo_pkg::clpo_sample_type scale(clpo_pkg::clpo_sample_type a, clpo_pkg::clpo_gain_type g);
        logic [`CLPO_ADC_W+`CLPO_GAIN_W-1:0] p;
        p = a * g;
        if (p[`CLPO_ADC_W+`CLPO_GAIN_W-1:`CLPO_ADC_W+`CLPO_GAIN_SH] != '0) begin
            return '1;
        end
        return p[`CLPO_ADC_W+`CLPO_GAIN_SH-1:`CLPO_GAIN_SH];
    endfunction
    // ==========================================================
    // stages
    logic [4:0] v_ff;
    logic first_ff;
    logic [CW-1:0] col_ff;
    clpo_pkg::clpo_pix_type s1_ff, s2_ff, s3_ff, s4_ff, s5_ff;
    logic [PBW-1:0] ptr_b_ff, cur_b;
    logic [PGW-1:0] ptr_g_ff, cur_g;
    clpo_pkg::clpo_sample_type mem_b [2*LINE_GAP][LINE_PIX];
    clpo_pkg::clpo_sample_type mem_g [LINE_GAP][LINE_PIX];

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            v_ff <= '0;
            vld_o <= 1'b0;
        end else begin
            v_ff <= {v_ff[3:0], vld_i};
            vld_o <= v_ff[4];
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (vld_i) begin
            first_ff <= first_i;
            col_ff <= col_i;
            s1_ff.r <= sub_sat(pix_i.r, corr_i.black);
            s1_ff.g <= sub_sat(pix_i.g, corr_i.black);
            s1_ff.b <= sub_sat(pix_i.b, corr_i.black);
        end
        if (v_ff[0]) begin
            s2_ff.r <= scale(s1_ff.r, corr_i.gain);
            s2_ff.g <= scale(s1_ff.g, corr_i.gain);
            s2_ff.b <= scale(s1_ff.b, corr_i.gain);
        end
        if (v_ff[1]) begin
            s3_ff.r <= add_sat(scale(s2_ff.r, corr_i.contrast), corr_i.bright);
            s3_ff.g <= add_sat(scale(s2_ff.g, corr_i.contrast), corr_i.bright);
            s3_ff.b <= add_sat(scale(s2_ff.b, corr_i.contrast), corr_i.bright);
        end
    end
    // ==========================================================
    // line_buffer_memory: blue sees a point first, so it waits longest
    always_comb begin
        cur_b = ptr_b_ff;
        cur_g = ptr_g_ff;
        if (first_ff) begin
            cur_b = (ptr_b_ff == PBW'(2 * LINE_GAP - 1)) ? '0 : ptr_b_ff + 1'b1;
            cur_g = (ptr_g_ff == PGW'(LINE_GAP - 1)) ? '0 : ptr_g_ff + 1'b1;
        end
    end
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr_b_ff <= '0;
            ptr_g_ff <= '0;
        end else if (v_ff[2]) begin
            ptr_b_ff <= cur_b;
            ptr_g_ff <= cur_g;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (v_ff[2]) begin
            mem_b[cur_b][col_ff] <= s3_ff.b;
            mem_g[cur_g][col_ff] <= s3_ff.g;
            s4_ff.r <= s3_ff.r;
            s4_ff.g <= mem_g[cur_g][col_ff];
            s4_ff.b <= mem_b[cur_b][col_ff];
        end
        // matrix stage holds the identity and takes no coefficients
        if (v_ff[3]) begin
            s5_ff <= s4_ff;
        end
        if (v_ff[4]) begin
            rgb_o.r <= s5_ff.r[`CLPO_ADC_W-1 -: `CLPO_BYTE_W];
            rgb_o.g <= s5_ff.g[`CLPO_ADC_W-1 -: `CLPO_BYTE_W];
            rgb_o.b <= s5_ff.b[`CLPO_ADC_W-1 -: `CLPO_BYTE_W];
        end
    end
endmodule
`default_nettype wire

//--- clpo_pixel_output.sv
// pixel path from converter to two camera link connectors
`include "clpo_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module clpo_pixel_output #(
    parameter int LINE_PIX = `CLPO_LINE_PIX,
    parameter int LINE_GAP = `CLPO_LINE_GAP,
    parameter int AUX_WORDS = `CLPO_AUX_WORDS,
    localparam int CW = $clog2(LINE_PIX)
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_link_i,
    input wire clpo_pkg::clpo_tap_in_type adc_i,
    output logic adc_rdy_o,
    input wire logic test_en_i,
    input wire logic grey_en_i,
    input wire logic area_en_i,
    input wire logic aux_en_i,
    input wire logic ext_height_en_i,
    input wire logic [`CLPO_HEIGHT_W-1:0] height_i,
    input wire logic trig_i,
    input wire logic ext_frame_i,
    input wire clpo_pkg::clpo_corr_type corr_i,
    output logic [`CLPO_TX_W-1:0] cl1_tx_o,
    output logic [`CLPO_TX_W-1:0] cl2_tx_o
);
    if (AUX_WORDS < 1 || AUX_WORDS >= (1 << `CLPO_AUX_CNT_W) || LINE_PIX < 2) begin : g_chk
        $error("aux word count or line length out of range");
    end
    // ==========================================================
    // helpers
    function automatic clpo_pkg::clpo_byte_type grey(clpo_pkg::clpo_rgb8_type p);
        logic [`CLPO_BYTE_W+1:0] s;
        s = {2'b00, p.r} + {1'b0, p.g, 1'b0} + {2'b00, p.b};
        return s[`CLPO_BYTE_W+1:2];
    endfunction

    function automatic logic [`CLPO_TX_W-1:0] tx_map(clpo_pkg::clpo_rgb8_type px, clpo_pkg::clpo_ctrl_type c);
        logic [`CLPO_TX_W-1:0] t;
        logic [`CLPO_POS_LIST_W-1:0] pa;
        logic [`CLPO_POS_LIST_W-1:0] pb;
        logic [`CLPO_POS_LIST_W-1:0] pc;
        t = '0;
        pa = `CLPO_TX_POS_A;
        pb = `CLPO_TX_POS_B;
        pc = `CLPO_TX_POS_C;
        for (int i = 0; i < `CLPO_BYTE_W; i++) begin
            t[pa[i*`CLPO_POS_W +: `CLPO_POS_W]] = px.r[i];
            t[pb[i*`CLPO_POS_W +: `CLPO_POS_W]] = px.g[i];
            t[pc[i*`CLPO_POS_W +: `CLPO_POS_W]] = px.b[i];
        end
        t[`CLPO_TX_SPARE] = 1'b0;
        t[`CLPO_TX_LVAL] = c.lval;
        t[`CLPO_TX_FVAL] = c.fval;
        t[`CLPO_TX_DVAL] = c.pen;
        return t;
    endfunction

    // ==========================================================
    // pin synchronisers
    logic [1:0] trig_sync_ff;
    logic [1:0] ext_sync_ff;
    logic trig_dly_ff;
    logic trig_rise;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trig_sync_ff <= '0;
            ext_sync_ff <= '0;
            trig_dly_ff <= 1'b0;
        end else begin
            trig_sync_ff <= {trig_sync_ff[0], trig_i};
            ext_sync_ff <= {ext_sync_ff[0], ext_frame_i};
            trig_dly_ff <= trig_sync_ff[1];
        end
    end
    assign trig_rise = trig_sync_ff[1] & ~trig_dly_ff;

    // ==========================================================
    // source selection, one pixel pair in flight at a time
    logic rdy_ff;
    logic nxt_rdy;
    logic done;
    logic accept;
    logic [CW-1:0] col_ff;
    logic [CW-1:0] cur_col;
    logic [CW-1:0] tp_col_ff;
    clpo_pkg::clpo_tap_in_type src;

    always_comb begin
        src = adc_i;
        if (test_en_i) begin
            src.vld = 1'b1;
            src.first = (tp_col_ff == '0);
            src.last = (tp_col_ff == CW'(LINE_PIX - 1));
            src.front.r = clpo_pkg::clpo_sample_type'(tp_col_ff) << `CLPO_BYTE_W;
            src.front.g = '1;
            src.front.b = '0;
            src.rear.r = '0;
            src.rear.g = clpo_pkg::clpo_sample_type'(tp_col_ff) << `CLPO_BYTE_W;
            src.rear.b = '1;
        end
    end
    assign accept = test_en_i ? rdy_ff : (adc_rdy_o & adc_i.vld);
    assign nxt_rdy = accept ? 1'b0 : (done ? 1'b1 : rdy_ff);
    assign cur_col = (src.first || col_ff == CW'(LINE_PIX - 1)) ? '0 : col_ff + 1'b1;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdy_ff <= 1'b1;
            adc_rdy_o <= 1'b0;
            col_ff <= '0;
            tp_col_ff <= '0;
        end else begin
            rdy_ff <= nxt_rdy;
            adc_rdy_o <= nxt_rdy & ~test_en_i;
            if (accept) begin
                col_ff <= cur_col;
            end
            if (accept && test_en_i) begin
                tp_col_ff <= (tp_col_ff == CW'(LINE_PIX - 1)) ? '0 : tp_col_ff + 1'b1;
            end
        end
    end

    // ==========================================================
    // frame emulation
    clpo_pkg::clpo_frame_type fr_ff;
    logic [`CLPO_HEIGHT_W-1:0] lines_ff;
    logic [`CLPO_HEIGHT_W-1:0] line_no_ff;
    logic last_line_ff;
    clpo_pkg::clpo_flags_type meta_ff;

    function automatic logic ends_frame(logic [`CLPO_HEIGHT_W-1:0] n, logic ext_sel, logic ext_lvl,
                                        logic [`CLPO_HEIGHT_W-1:0] h);
        return ext_sel ? ~ext_lvl : (n >= h);
    endfunction

    // trigger arms, next line opens the frame
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fr_ff <= clpo_pkg::CLPO_FR_IDLE;
            lines_ff <= '0;
            last_line_ff <= 1'b0;
        end else if (!area_en_i) begin
            fr_ff <= clpo_pkg::CLPO_FR_IDLE;
            last_line_ff <= 1'b0;
        end else begin
            case (fr_ff)
                clpo_pkg::CLPO_FR_IDLE: begin
                    if (trig_rise) begin
                        fr_ff <= clpo_pkg::CLPO_FR_ARMED;
                    end
                end
                clpo_pkg::CLPO_FR_ARMED: begin
                    if (accept && src.first) begin
                        fr_ff <= clpo_pkg::CLPO_FR_ACTIVE;
                        lines_ff <= `CLPO_HEIGHT_W'(1);
                        last_line_ff <= ends_frame(`CLPO_HEIGHT_W'(1), ext_height_en_i, ext_sync_ff[1], height_i);
                    end
                end
                clpo_pkg::CLPO_FR_ACTIVE: begin
                    if (accept && src.first) begin
                        lines_ff <= lines_ff + 1'b1;
                        last_line_ff <= ends_frame(lines_ff + 1'b1, ext_height_en_i, ext_sync_ff[1], height_i);
                    end else if (accept && src.last && last_line_ff) begin
                        fr_ff <= clpo_pkg::CLPO_FR_IDLE;
                    end
                end
                default: begin
                    fr_ff <= clpo_pkg::CLPO_FR_IDLE;
                end
            endcase
        end
    end

    // frame flags only in area mode
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= '0;
            line_no_ff <= '0;
        end else if (accept) begin
            meta_ff.line_first <= src.first;
            meta_ff.line_last <= src.last;
            meta_ff.frame_first <= src.first && area_en_i && (fr_ff == clpo_pkg::CLPO_FR_ARMED);
            meta_ff.frame_last <= src.last && !src.first && area_en_i && last_line_ff
                                  && (fr_ff == clpo_pkg::CLPO_FR_ACTIVE);
            if (src.first) begin
                line_no_ff <= line_no_ff + 1'b1;
            end
        end
    end

    // ==========================================================
    // two taps through identical chains
    logic chain_vld;
    clpo_pkg::clpo_rgb8_type front_rgb;
    clpo_pkg::clpo_rgb8_type rear_rgb;

    clpo_tap_chain #(.LINE_PIX(LINE_PIX), .LINE_GAP(LINE_GAP)) u_front (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .vld_i(accept),
        .first_i(src.first),
        .col_i(cur_col),
        .pix_i(src.front),
        .corr_i(corr_i),
        .vld_o(chain_vld),
        .rgb_o(front_rgb)
    );
    clpo_tap_chain #(.LINE_PIX(LINE_PIX), .LINE_GAP(LINE_GAP)) u_rear (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .vld_i(accept),
        .first_i(src.first),
        .col_i(cur_col),
        .pix_i(src.rear),
        .corr_i(corr_i),
        .vld_o(),
        .rgb_o(rear_rgb)
    );

    // ==========================================================
    // word formatter and sending slot
    logic pend_ff;
    logic [`CLPO_AUX_CNT_W-1:0] aux_cnt_ff;
    logic req_ff;
    logic [1:0] ack_sync_ff;
    clpo_pkg::clpo_word_type word_ff;
    clpo_pkg::clpo_word_type pix_word;
    clpo_pkg::clpo_word_type aux_word;
    logic slot_free;
    logic send_pix;
    logic send_aux;
    logic add_aux;
    logic aux_tail;

    assign slot_free = (req_ff == ack_sync_ff[1]);
    assign send_pix = pend_ff & slot_free;
    assign send_aux = ~pend_ff & (aux_cnt_ff != '0) & slot_free;
    assign add_aux = aux_en_i & meta_ff.line_last;
    assign aux_tail = (aux_cnt_ff == `CLPO_AUX_CNT_W'(1));
    assign done = (send_pix & ~add_aux) | (send_aux & aux_tail);

    always_comb begin
        pix_word.flags = meta_ff;
        pix_word.flags.line_last = meta_ff.line_last & ~add_aux;
        pix_word.flags.frame_last = meta_ff.frame_last & ~add_aux;
        // colour: both connectors, one pixel each
        pix_word.con1 = front_rgb;
        pix_word.con2 = rear_rgb;
        // grey: connector one, front then rear
        if (grey_en_i) begin
            pix_word.con1.r = grey(front_rgb);
            pix_word.con1.g = grey(rear_rgb);
            pix_word.con1.b = '0;
            pix_word.con2 = '0;
        end
        // trailing words carry line number and index
        aux_word.flags.frame_first = 1'b0;
        aux_word.flags.line_first = 1'b0;
        aux_word.flags.line_last = aux_tail;
        aux_word.flags.frame_last = meta_ff.frame_last & aux_tail;
        aux_word.con1.r = line_no_ff[`CLPO_HEIGHT_W-1 -: `CLPO_BYTE_W];
        aux_word.con1.g = line_no_ff[`CLPO_BYTE_W-1:0];
        aux_word.con1.b = clpo_pkg::clpo_byte_type'(aux_cnt_ff);
        aux_word.con2 = '0;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_ff <= 1'b0;
            aux_cnt_ff <= '0;
            req_ff <= 1'b0;
            word_ff <= '0;
        end else begin
            if (send_pix) begin
                word_ff <= pix_word;
                req_ff <= ~req_ff;
                pend_ff <= 1'b0;
                if (add_aux) begin
                    aux_cnt_ff <= `CLPO_AUX_CNT_W'(AUX_WORDS);
                end
            end else if (send_aux) begin
                word_ff <= aux_word;
                req_ff <= ~req_ff;
                aux_cnt_ff <= aux_cnt_ff - 1'b1;
            end
            if (chain_vld) begin
                pend_ff <= 1'b1;
            end
        end
    end

    // ==========================================================
    // link domain: toggle handshake, word is stable while request differs
    logic [1:0] lrst_ff;
    logic [1:0] req_sync_ff;
    logic seen_ff;
    logic cap;
    logic lend_ff;
    logic fend_ff;
    clpo_pkg::clpo_word_type data_ff;
    clpo_pkg::clpo_word_type nxt_data;
    clpo_pkg::clpo_ctrl_type ctl_ff;
    clpo_pkg::clpo_ctrl_type nxt_ctl;

    always_ff @(posedge clk_link_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lrst_ff <= '0;
        end else begin
            lrst_ff <= {lrst_ff[0], 1'b1};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_sync_ff <= '0;
        end else begin
            ack_sync_ff <= {ack_sync_ff[0], seen_ff};
        end
    end

    assign cap = req_sync_ff[1] ^ seen_ff;

    // line valid spans the words of a line, enable marks each word
    always_comb begin
        nxt_data = cap ? word_ff : data_ff;
        nxt_ctl.pen = cap;
        nxt_ctl.lval = cap | (ctl_ff.lval & ~lend_ff);
        nxt_ctl.fval = cap ? (ctl_ff.fval | word_ff.flags.frame_first) : (ctl_ff.fval & ~fend_ff);
    end

    always_ff @(posedge clk_link_i or negedge lrst_ff[1]) begin
        if (!lrst_ff[1]) begin
            req_sync_ff <= '0;
            seen_ff <= 1'b0;
            lend_ff <= 1'b0;
            fend_ff <= 1'b0;
            data_ff <= '0;
            ctl_ff <= '0;
            cl1_tx_o <= '0;
            cl2_tx_o <= '0;
        end else begin
            req_sync_ff <= {req_sync_ff[0], req_ff};
            seen_ff <= req_sync_ff[1];
            lend_ff <= cap & word_ff.flags.line_last;
            fend_ff <= cap & word_ff.flags.frame_last;
            data_ff <= nxt_data;
            ctl_ff <= nxt_ctl;
            cl1_tx_o <= tx_map(nxt_data.con1, nxt_ctl);
            cl2_tx_o <= tx_map(nxt_data.con2, nxt_ctl);
        end
    end
endmodule
`default_nettype wire

//--- clpo_fg_model.sv
// frame grabber model: decodes camera link words into a queue
`timescale 1ns/1ps
`default_nettype none
module clpo_fg_model (
    input wire logic clk_link_i,
    input wire logic [27:0] cl1_tx_i,
    input wire logic [27:0] cl2_tx_i
);
    // entry: fval, connector one bytes, connector two bytes
    logic [48:0] q[$];
    function automatic logic [23:0] dec(input logic [27:0] t);
        return {t[5], t[27], t[6], t[4], t[3], t[2], t[1], t[0], t[11], t[10], t[14], t[13], t[12], t[9], t[8],
            t[7], t[17], t[16], t[22], t[21], t[20], t[19], t[18], t[15]};
    endfunction
    always @(posedge clk_link_i) begin
        if (cl1_tx_i[26] === 1'b1) begin
            q.push_back({cl1_tx_i[25], dec(cl1_tx_i), dec(cl2_tx_i)});
        end
    end
endmodule
`default_nettype wire

//--- clpo_pixel_output_assertions.sv
// concurrent checks on the pixel output ports
`timescale 1ns/1ps
`default_nettype none
module clpo_chk (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_link_i,
    input wire clpo_pkg::clpo_tap_in_type adc_i,
    input wire logic adc_rdy_o,
    input wire logic test_en_i,
    input wire logic grey_en_i,
    input wire logic area_en_i,
    input wire logic [27:0] cl1_tx_o,
    input wire logic [27:0] cl2_tx_o
);
    rdy_take_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        adc_rdy_o && adc_i.vld && !test_en_i |=> !adc_rdy_o) else $error("ready held after take");
    test_rdy_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        test_en_i [*2] |-> !adc_rdy_o) else $error("ready during test image");
    dval_gap_a: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
        cl1_tx_o[26] |=> (!cl1_tx_o[26]) [*2]) else $error("pixel enable too long");
    lval_dval_a: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
        cl1_tx_o[26] |-> cl1_tx_o[24]) else $error("word outside line valid");
    ctrl_pair_a: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
        {cl1_tx_o[26:23], cl2_tx_o[23]} == {cl2_tx_o[26:24], 2'b00}) else $error("control bits differ");
    line_fval_a: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
        (!area_en_i) [*8] |-> !cl1_tx_o[25]) else $error("frame valid in line scan");
    fval_end_a: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
        $fell(cl1_tx_o[25]) |-> $fell(cl1_tx_o[24])) else $error("frame valid fell alone");
    grey_zero_a: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
        grey_en_i [*8] ##0 cl1_tx_o[26] |-> (cl2_tx_o & 28'h87fffff) == 28'h0) else $error("grey data on two");
    c_take: cover property (@(posedge clk_sys_i) adc_rdy_o && adc_i.vld);
    c_grey: cover property (@(posedge clk_link_i) grey_en_i && cl1_tx_o[26]);
    c_frame: cover property (@(posedge clk_link_i) $rose(cl1_tx_o[25]));
endmodule
bind clpo_pixel_output clpo_chk u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_link_i(clk_link_i),
    .adc_i(adc_i), .adc_rdy_o(adc_rdy_o), .test_en_i(test_en_i), .grey_en_i(grey_en_i),
    .area_en_i(area_en_i), .cl1_tx_o(cl1_tx_o), .cl2_tx_o(cl2_tx_o));
`default_nettype wire

//--- testbench.sv
// self-checking bench of the pixel output block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys_i = 1'b0;
    logic clk_link_i = 1'b0;
    logic rst_n_i = 1'b0;
    clpo_pkg::clpo_tap_in_type adc_i = '0;
    logic adc_rdy_o, test_en_i = 1'b0, grey_en_i = 1'b0, area_en_i = 1'b0, aux_en_i = 1'b0, trig_i = 1'b0;
    logic ext_height_en_i = 1'b0, ext_frame_i = 1'b1;
    logic [15:0] height_i = 16'h0002;
    logic [27:0] cl1_tx_o, cl2_tx_o;
    int n_mismatch = 0, tests_run = 0, cyc = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    initial #37 forever #80 clk_link_i = ~clk_link_i;
    // small line and gap keep the run short
    clpo_pixel_output #(.LINE_PIX(4), .LINE_GAP(2), .AUX_WORDS(2)) u_dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_link_i(clk_link_i), .adc_i(adc_i), .adc_rdy_o(adc_rdy_o),
        .test_en_i(test_en_i), .grey_en_i(grey_en_i), .area_en_i(area_en_i), .aux_en_i(aux_en_i),
        .ext_height_en_i(ext_height_en_i), .height_i(height_i), .trig_i(trig_i), .ext_frame_i(ext_frame_i),
        .corr_i({14'h0000, 8'h80, 14'h0000, 8'h80}), .cl1_tx_o(cl1_tx_o), .cl2_tx_o(cl2_tx_o));
    clpo_fg_model u_fg (.clk_link_i(clk_link_i), .cl1_tx_i(cl1_tx_o), .cl2_tx_i(cl2_tx_o));
    task automatic chk(input logic [48:0] seen, input logic [48:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // flat pixels, so delayed colours match once the line buffer has filled
    task automatic run(input int lines, input int words);
        u_fg.q.delete();
        for (int l = 0; l < lines; l++) begin
            for (int i = 0; i < 4; i++) begin
                adc_i <= {1'b1, i == 0, i == 3, {3{14'h1a40}}, {3{14'h0c80}}};
                do @(posedge clk_sys_i); while (adc_rdy_o !== 1'b1);
            end
        end
        adc_i <= '0;
        while (u_fg.q.size() < words) @(posedge clk_sys_i);
    endtask
    task automatic t_colour();
        run(6, 24);
        chk(u_fg.q[23], {1'b0, {3{8'h69}}, {3{8'h32}}});
        $display("colour done");
    endtask
    task automatic t_grey();
        grey_en_i <= 1'b1;
        run(1, 4);
        chk(u_fg.q[3], {1'b0, 8'h69, 8'h32, 8'h00, 24'h0});
        grey_en_i <= 1'b0;
        $display("grey done");
    endtask
    task automatic t_aux();
        aux_en_i <= 1'b1;
        run(1, 6);
        chk(u_fg.q[4], {1'b0, 8'h00, 8'h08, 8'h02, 24'h0});
        chk(u_fg.q[5], {1'b0, 8'h00, 8'h08, 8'h01, 24'h0});
        aux_en_i <= 1'b0;
        $display("aux done");
    endtask
    task automatic t_area();
        area_en_i <= 1'b1;
        // second frame is cut to one line by the external height pin
        for (int k = 0; k < 2; k++) begin
            ext_height_en_i <= k[0];
            ext_frame_i <= ~k[0];
            trig_i <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            trig_i <= 1'b0;
            repeat (4) @(posedge clk_sys_i);
            run(3 - k, 12 - 4 * k);
            chk({46'h0, u_fg.q[0][48], u_fg.q[7 - 4 * k][48], u_fg.q[8 - 4 * k][48]}, {46'h0, 3'b110});
        end
        area_en_i <= 1'b0;
        ext_height_en_i <= 1'b0;
        $display("area done");
    endtask
    task automatic t_test();
        test_en_i <= 1'b1;
        u_fg.q.delete();
        repeat (600) @(posedge clk_sys_i);
        chk({47'h0, adc_rdy_o, u_fg.q.size() != 0}, {47'h0, 2'b01});
        chk({33'h0, u_fg.q[1][47:40], u_fg.q[1][23:16]}, {33'h0, 8'h04, 8'h00});
        test_en_i <= 1'b0;
        $display("test image done");
    endtask
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_colour();
        t_grey();
        t_aux();
        t_area();
        t_test();
        stop_test();
    end
endmodule
`default_nettype wire
